// ===== core/tws_defs.svh
// register offsets, field positions, reset values and status codes of the receiver
`ifndef TWS_DEFS_SVH
`define TWS_DEFS_SVH
`define TWS_ADDR_W      2
`define TWS_OFS_CTRL    2'h0
`define TWS_OFS_STAT    2'h1
`define TWS_OFS_OWN     2'h2
`define TWS_OFS_DATA    2'h3
`define TWS_B_IRQ       7
`define TWS_B_ACK       6
`define TWS_B_BEGIN     5
`define TWS_B_HALT      4
`define TWS_B_WCOL      3
`define TWS_B_EN        2
`define TWS_B_IRQEN     0
`define TWS_BITS_BYTE   4'h8
`define TWS_RST_BYTE    8'h00
`define TWS_ST_IDLE     8'hf8
`define TWS_ST_OWN      8'h60
`define TWS_ST_OWN_ARB  8'h68
`define TWS_ST_GC       8'h70
`define TWS_ST_GC_ARB   8'h78
`define TWS_ST_D_ACK    8'h80
`define TWS_ST_D_NACK   8'h88
`define TWS_ST_GD_ACK   8'h90
`define TWS_ST_GD_NACK  8'h98
`define TWS_ST_STOP     8'ha0
`endif

// ===== core/tws_pkg.sv
// types shared by the two-wire slave receiver modules
package tws_pkg;
   // receiver states, one-hot
   typedef enum logic [6:0] {
      TWS_S_IDLE = 7'h01,
      TWS_S_ADDR = 7'h02,
      TWS_S_AACK = 7'h04,
      TWS_S_DATA = 7'h08,
      TWS_S_DACK = 7'h10,
      TWS_S_WAIT = 7'h20,
      TWS_S_SKIP = 7'h40
   } tws_state_t;

   // line sampler state
   typedef struct packed {
      logic [1:0] meta;     // first stage, scl then sda
      logic [1:0] sync;     // second stage
      logic [1:0] prev;     // previous synced value
   } tws_smp_t;

   // receiver state
   typedef struct packed {
      tws_state_t state;
      logic [3:0] bits;       // bits shifted in this byte
      logic [7:0] shift;      // incoming byte
      logic       irq_flag;
      logic       ack_enable;
      logic       begin_request;
      logic       halt_request;
      logic       write_collision_flag;
      logic       iface_enable;
      logic       irq_enable;
      logic [7:0] code;       // status code
      logic [1:0] presc;      // prescaler bits of the status register
      logic [7:0] own_addr;
      logic [7:0] data;
      logic       gc;         // addressed by general call
      logic       arb;        // addressed after lost arbitration
      logic       resume;     // after flag clear, receive another byte
      logic       start_pend;
      logic       start_go;
      logic       busy;
      logic       wake;
      logic       tx_mode;
      logic       sda_oe_n;
      logic       scl_oe_n;
      logic       low;        // constant pin level for open drain
      logic [7:0] rdata;
   } tws_regs_t;
endpackage

// ===== core/tws_sampler.sv
// two-flop synchroniser and edge / start / stop detection for the bus lines
`timescale 1ns/1ps
`default_nettype none
module tws_sampler (
   input  wire logic clock_i,
   input  wire logic rst_i,
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      scl_rise_o,
   output logic      scl_fall_o,
   output logic      start_o,
   output logic      stop_o,
   output logic      sda_lvl_o
);
   tws_pkg::tws_smp_t s_reg;   // all sampler state
   tws_pkg::tws_smp_t s_next;

   // next-state: the first stage is read only by the second stage
   always_comb begin
      s_next      = s_reg;
      s_next.meta = {scl_i, sda_i};
      s_next.sync = s_reg.meta;
      s_next.prev = s_reg.sync;
   end

   // registers; idle bus is both lines high
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         s_reg <= '{meta: 2'h3, sync: 2'h3, prev: 2'h3};
      end else begin
         s_reg <= s_next;
      end
   end

   // edges decoded straight off the synced pair: a registered stage here
   // would push the ack drive up against the master's next clock rise
   assign scl_rise_o = s_reg.sync[1] & ~s_reg.prev[1];
   assign scl_fall_o = ~s_reg.sync[1] & s_reg.prev[1];
   // sda moving while scl stays high marks a start or stop
   assign start_o    = s_reg.sync[1] & s_reg.prev[1] & ~s_reg.sync[0] & s_reg.prev[0];
   assign stop_o     = s_reg.sync[1] & s_reg.prev[1] & s_reg.sync[0] & ~s_reg.prev[0];
   assign sda_lvl_o  = s_reg.sync[0];
endmodule
`default_nettype wire

// ===== core/tws_slave_rx.sv
// two-wire slave receiver: address match, byte reception, status codes, wake-up
//
// Contract
// RQ1: software enables interface and ack, clears begin/halt
// RQ2: acknowledge own or general call only with ack
// RQ3: write direction bit selects receive, else transmit
// RQ4: own address plus write sets flag and status
// RQ5: lost arbitration then addressed reports 0x68/0x78
// RQ6: ack cleared gives nack after next byte
// RQ7: ack clear ignores address, keeps monitoring bus
// RQ8: deep sleep still acknowledges address, wakes part
// RQ9: hold clock low through wake until clear
// RQ10: data register unreliable after sleep wake-up
// RQ11: flag cleared by writing one; resume after
// RQ12: own address acknowledged reports 0x60 or 0x68
// RQ13: general call acknowledged reports 0x70 or 0x78
// RQ14: clear flag, next byte acked per ack enable
// RQ15: acked own data reports 0x80, byte readable
// RQ16: nacked data reports 0x88, not addressed
// RQ17: begin request at 0x88 starts when free
// RQ18: status codes read with prescaler bits masked
// RQ19: own address upper seven, bit zero general call
// RQ20: general call data reports 0x90 or 0x98
// RQ21: stop or repeated start addressed gives 0xa0
// RQ22: msb first, clock stretched while flag pending; the 0xa0 flag is set with no stretch
`include "tws_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tws_slave_rx (
   input  wire logic                   clock_i,
   input  wire logic                   rst_i,
   // register port
   input  wire logic [`TWS_ADDR_W-1:0] addr_i,
   input  wire logic [7:0]             wdata_i,
   input  wire logic                   wr_i,
   input  wire logic                   rd_i,
   output logic      [7:0]             rdata_o,
   // bus pins, open drain, enable low while driving
   input  wire logic                   scl_i,
   output logic                        scl_o,
   output logic                        scl_oe_n_o,
   input  wire logic                   sda_i,
   output logic                        sda_o,
   output logic                        sda_oe_n_o,
   // system side
   input  wire logic                   arb_lost_i,
   input  wire logic                   sleep_i,
   output logic                        wake_o,
   output logic                        tx_mode_o,
   output logic                        start_go_o
);
   tws_pkg::tws_regs_t r_reg;    // all receiver state
   tws_pkg::tws_regs_t r_next;
   logic               scl_rise; // synced scl rising edge
   logic               scl_fall; // synced scl falling edge
   logic               start_det;
   logic               stop_det;
   logic               sda_lvl;  // synced data level

   // line sampler; its edges lag the pins by one to two clocks
   tws_sampler u_smp (
      .clock_i    (clock_i),
      .rst_i      (rst_i),
      .scl_i      (scl_i),
      .sda_i      (sda_i),
      .scl_rise_o (scl_rise),
      .scl_fall_o (scl_fall),
      .start_o    (start_det),
      .stop_o     (stop_det),
      .sda_lvl_o  (sda_lvl)
   );

   // address decision: 1 own match, 2 general call, 0 none
   function automatic logic [1:0] addr_hit(input logic [7:0] rx, input logic [7:0] own);
      logic [1:0] hit;
      hit = 2'h0;
      if (rx[7:1] == own[7:1]) begin
         hit = 2'h1;
      end else if (rx[7:1] == 7'h00 && own[0]) begin // RQ19
         hit = 2'h2;
      end
      return hit;
   endfunction

   // status code for an accepted address
   function automatic logic [7:0] addr_code(input logic gc, input logic arb);
      logic [7:0] c;
      if (gc) begin
         c = arb ? `TWS_ST_GC_ARB : `TWS_ST_GC; // RQ13 RQ5
      end else begin
         c = arb ? `TWS_ST_OWN_ARB : `TWS_ST_OWN; // RQ12 RQ5
      end
      return c;
   endfunction

   // status code for a received data byte
   function automatic logic [7:0] data_code(input logic gc, input logic ack);
      logic [7:0] c;
      if (gc) begin
         c = ack ? `TWS_ST_GD_ACK : `TWS_ST_GD_NACK; // RQ20
      end else begin
         c = ack ? `TWS_ST_D_ACK : `TWS_ST_D_NACK; // RQ15 RQ16
      end
      return c;
   endfunction

   // next-state logic
   always_comb begin
      logic       clr;
      logic [1:0] hit;
      r_next          = r_reg;
      r_next.start_go = 1'b0;
      clr             = 1'b0;
      hit             = addr_hit(r_reg.shift, r_reg.own_addr);

      // register writes
      if (wr_i) begin
         unique case (addr_i)
            `TWS_OFS_CTRL: begin
               r_next.ack_enable    = wdata_i[`TWS_B_ACK];
               r_next.begin_request = wdata_i[`TWS_B_BEGIN];
               r_next.halt_request  = wdata_i[`TWS_B_HALT];
               r_next.iface_enable  = wdata_i[`TWS_B_EN];
               r_next.irq_enable    = wdata_i[`TWS_B_IRQEN];
               // writing one clears the flag, a zero leaves it
               clr = wdata_i[`TWS_B_IRQ] & r_reg.irq_flag; // RQ11
               if (clr) begin
                  r_next.irq_flag = 1'b0;
               end
            end
            `TWS_OFS_STAT: begin
               r_next.presc = wdata_i[1:0];
            end
            `TWS_OFS_OWN: begin
               r_next.own_addr = wdata_i;
            end
            `TWS_OFS_DATA: begin
               // the byte may only change while the flag is pending
               if (r_reg.irq_flag) begin
                  r_next.data                 = wdata_i;
                  r_next.write_collision_flag = 1'b0;
               end else begin
                  r_next.write_collision_flag = 1'b1;
               end
            end
         endcase
      end

      // register reads, answered in the next cycle
      if (rd_i) begin
         unique case (addr_i)
            `TWS_OFS_CTRL: r_next.rdata = {r_reg.irq_flag, r_reg.ack_enable,
                                           r_reg.begin_request, r_reg.halt_request,
                                           r_reg.write_collision_flag, r_reg.iface_enable,
                                           1'b0, r_reg.irq_enable};
            // code in the upper five bits, prescaler bits below
            `TWS_OFS_STAT: r_next.rdata = {r_reg.code[7:3], 1'b0, r_reg.presc}; // RQ18
            `TWS_OFS_OWN:  r_next.rdata = r_reg.own_addr;
            `TWS_OFS_DATA: r_next.rdata = r_reg.data;
         endcase
      end

      // bus busy between start and stop
      if (start_det) begin
         r_next.busy = 1'b1;
      end else if (stop_det) begin
         r_next.busy = 1'b0;
      end

      // pending start is handed to the master logic once the bus is free
      if (r_reg.start_pend && !r_reg.busy && !start_det) begin // RQ17
         r_next.start_go      = 1'b1;
         r_next.start_pend    = 1'b0;
         r_next.begin_request = 1'b0;
      end

      // wake request drops once the part runs again
      if (!sleep_i) begin
         r_next.wake = 1'b0;
      end

      // receiver sequence; hardware flag sets come after the clear so set wins
      unique case (r_reg.state)
         tws_pkg::TWS_S_IDLE: begin
            // not addressed, still watching for a start
            if (start_det && r_reg.iface_enable) begin
               r_next.state   = tws_pkg::TWS_S_ADDR;
               r_next.bits    = 4'h0;
               r_next.tx_mode = 1'b0;
            end
            // clear after 0xa0 may request a start
            if (clr && r_reg.code == `TWS_ST_STOP && r_next.begin_request) begin
               r_next.start_pend = 1'b1; // RQ17
            end
         end

         // address byte and direction bit, msb first
         tws_pkg::TWS_S_ADDR: begin
            if (stop_det) begin
               r_next.state = tws_pkg::TWS_S_IDLE;
            end else if (start_det) begin
               r_next.bits = 4'h0;
            end else if (scl_rise && r_reg.bits != `TWS_BITS_BYTE) begin
               r_next.shift = {r_reg.shift[6:0], sda_lvl}; // RQ22
               r_next.bits  = r_reg.bits + 4'h1;
            end else if (scl_fall && r_reg.bits == `TWS_BITS_BYTE) begin
               // with ack off the bus is watched, never answered
               if (hit != 2'h0 && r_reg.ack_enable) begin // RQ2 RQ7
                  // pull data low through the ninth clock
                  r_next.sda_oe_n = 1'b0;
                  r_next.state    = tws_pkg::TWS_S_AACK;
                  r_next.gc       = (hit == 2'h2);
                  r_next.arb      = arb_lost_i; // RQ5
                  // read direction belongs to the transmitter side
                  r_next.tx_mode  = r_reg.shift[0]; // RQ3
                  // the match itself wakes a sleeping part
                  if (sleep_i) begin
                     r_next.wake = 1'b1; // RQ8
                  end
               end else begin
                  // foreign address, or any address with ack off: sit out the frame
                  r_next.state = tws_pkg::TWS_S_SKIP;
               end
            end
         end

         // own or general call address acknowledged, wait for the ninth falling edge
         tws_pkg::TWS_S_AACK: begin
            if (scl_fall) begin
               // ack dropped while the clock is low
               r_next.sda_oe_n = 1'b1;
               r_next.bits     = 4'h0;
               if (r_reg.tx_mode) begin
                  // sending is not done here; only watch the bus
                  r_next.state = tws_pkg::TWS_S_SKIP;
               end else begin
                  // flag and status; clock held until software clears
                  r_next.irq_flag = 1'b1; // RQ4
                  r_next.code     = addr_code(r_reg.gc, r_reg.arb); // RQ12 RQ13
                  r_next.scl_oe_n = 1'b0; // RQ9
                  r_next.resume   = 1'b1;
                  r_next.state    = tws_pkg::TWS_S_WAIT;
               end
            end
         end

         // addressed, shifting a data byte
         tws_pkg::TWS_S_DATA: begin
            if (stop_det || start_det) begin
               // end of frame while addressed; no stretch, the bus is done
               r_next.irq_flag = 1'b1; // RQ21
               r_next.code     = `TWS_ST_STOP;
               r_next.bits     = 4'h0;
               if (start_det) begin
                  // repeated start: a new address follows at once
                  r_next.state = tws_pkg::TWS_S_ADDR;
               end else begin
                  r_next.state = tws_pkg::TWS_S_IDLE;
               end
            end else if (scl_rise && r_reg.bits != `TWS_BITS_BYTE) begin
               r_next.shift = {r_reg.shift[6:0], sda_lvl}; // RQ22
               r_next.bits  = r_reg.bits + 4'h1;
            end else if (scl_fall && r_reg.bits == `TWS_BITS_BYTE) begin
               // answer follows the enable bit as it stands at byte end
               r_next.sda_oe_n = ~r_reg.ack_enable; // RQ6 RQ14
               r_next.resume   = r_reg.ack_enable;
               r_next.state    = tws_pkg::TWS_S_DACK;
            end
         end

         // answer bit on the line, wait for the ninth falling edge
         tws_pkg::TWS_S_DACK: begin
            if (scl_fall) begin
               r_next.sda_oe_n = 1'b1;
               r_next.bits     = 4'h0;
               r_next.irq_flag = 1'b1;
               r_next.scl_oe_n = 1'b0; // RQ22
               // kept after a wake too, but software must not trust it then
               r_next.data     = r_reg.shift; // RQ15 RQ10
               r_next.code     = data_code(r_reg.gc, r_reg.resume); // RQ16 RQ20
               r_next.state    = tws_pkg::TWS_S_WAIT;
            end
         end

         // flag pending, clock stretched
         tws_pkg::TWS_S_WAIT: begin
            if (clr) begin
               // the clearing write alone lets the bus go on
               r_next.scl_oe_n = 1'b1; // RQ11
               r_next.bits     = 4'h0;
               if (r_reg.resume) begin
                  r_next.state = tws_pkg::TWS_S_DATA; // RQ14
               end else begin
                  // refused byte: not addressed until the next start
                  r_next.state = tws_pkg::TWS_S_SKIP; // RQ16
                  if (r_next.begin_request) begin
                     r_next.start_pend = 1'b1; // RQ17
                  end
               end
            end
         end

         // not addressed in this frame
         tws_pkg::TWS_S_SKIP: begin
            if (stop_det) begin
               r_next.state = tws_pkg::TWS_S_IDLE;
            end else if (start_det) begin
               r_next.state   = tws_pkg::TWS_S_ADDR;
               r_next.bits    = 4'h0;
               r_next.tx_mode = 1'b0;
            end
         end

         // broken one-hot code: back to not addressed, lines released
         default: begin
            r_next.state    = tws_pkg::TWS_S_IDLE;
            r_next.sda_oe_n = 1'b1;
            r_next.scl_oe_n = 1'b1;
         end
      endcase
   end

   // state register; reset releases both lines and shows the idle code
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         r_reg <= '{state:    tws_pkg::TWS_S_IDLE,
                    code:     `TWS_ST_IDLE,
                    own_addr: `TWS_RST_BYTE,
                    sda_oe_n: 1'b1,
                    scl_oe_n: 1'b1,
                    default:  '0};
      end else begin
         r_reg <= r_next;
      end
   end

   // every output comes straight from a state field
   assign rdata_o    = r_reg.rdata;
   // the pin drivers only ever pull low; the enables decide
   assign scl_o      = r_reg.low; // RQ9
   assign scl_oe_n_o = r_reg.scl_oe_n; // RQ22
   assign sda_o      = r_reg.low; // RQ6
   assign sda_oe_n_o = r_reg.sda_oe_n;
   assign wake_o     = r_reg.wake; // RQ8
   assign tx_mode_o  = r_reg.tx_mode; // RQ3
   assign start_go_o = r_reg.start_go; // RQ17
endmodule
`default_nettype wire

// ===== tb/tb_two_wire_slave_receiver.sv
// self-checking bench of the two-wire slave receiver
`timescale 1ns/1ps
`default_nettype none
`include "tws_defs.svh"
module tb_two_wire_slave_receiver;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, arb = 1'b0, slp = 1'b0, woke;
   logic [1:0] addr = 2'h0;
   logic [7:0] wdata = 8'h00, rdata, v;
   logic scl_o, scl_oe_n, sda_o, sda_oe_n, scl_m, sda_m, wake, tx, go;
   wire logic scl_w = scl_m & (scl_oe_n | scl_o);   // pulled-up wired and
   wire logic sda_w = sda_m & (sda_oe_n | sda_o);
   int errors = 0, checks_done = 0, cycles = 0;
   always #50 clk = ~clk;
   tws_slave_rx dut_u (.clock_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .scl_i(scl_w), .scl_o(scl_o),
      .scl_oe_n_o(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
      .arb_lost_i(arb), .sleep_i(slp), .wake_o(wake), .tx_mode_o(tx), .start_go_o(go));
   tws_master_model m_u (.scl_w_i(scl_w), .sda_w_i(sda_w), .scl_m_o(scl_m), .sda_m_o(sda_m));
   task automatic close_out();
      if (errors == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // read data stand from the cycle after the strobe until the next read
   task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // bounded wait until the slave stretches the clock
   task automatic hold();
      for (int n = 0; n < 60 && scl_oe_n !== 1'b0; n++) @(posedge clk);
   endtask
   logic went = 1'b0;
   always @(posedge clk) if (wake === 1'b1) woke = 1'b1;
   always @(posedge clk) if (go === 1'b1) went = 1'b1;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         errors++;
         close_out();
      end
   end
   // addressed write, one accepted byte, one refused byte, stop
   task automatic rx_case(input logic [7:0] sla, input logic a, input logic s,
                          input logic [7:0] st_a, input logic [7:0] st_d);
      logic ack;
      @(posedge clk);
      arb <= a;
      slp <= s;
      woke = 1'b0;
      m_u.start();
      m_u.send(sla, ack);
      cmp8({7'h00, ack}, 8'h00);
      hold();
      cmp8({7'h00, woke}, {7'h00, s});
      arb <= 1'b0;
      slp <= 1'b0;
      rd_reg(`TWS_OFS_STAT, v);
      cmp8(v & 8'hf8, st_a);
      wr_reg(`TWS_OFS_CTRL, 8'hc4);
      m_u.send(8'ha5, ack);
      cmp8({7'h00, ack}, 8'h00);
      hold();
      rd_reg(`TWS_OFS_STAT, v);
      cmp8(v & 8'hf8, st_d);
      rd_reg(`TWS_OFS_DATA, v);
      cmp8(v, 8'ha5);
      wr_reg(`TWS_OFS_CTRL, 8'h84);
      m_u.send(8'h3c, ack);
      cmp8({7'h00, ack}, 8'h01);
      hold();
      rd_reg(`TWS_OFS_STAT, v);
      cmp8(v & 8'hf8, st_d + 8'h08);
      wr_reg(`TWS_OFS_CTRL, 8'hc4);
      m_u.stop();
   endtask
   // refusal with acknowledge off, foreign address, then stop while addressed
   task automatic off_case();
      logic ack;
      wr_reg(`TWS_OFS_CTRL, 8'h04);
      m_u.start();
      m_u.send(8'h54, ack);
      cmp8({7'h00, ack}, 8'h01);
      m_u.stop();
      wr_reg(`TWS_OFS_CTRL, 8'h44);
      m_u.start();
      m_u.send(8'h5a, ack);
      cmp8({7'h00, ack}, 8'h01);
      m_u.stop();
      m_u.start();
      m_u.send(8'h55, ack);
      cmp8({7'h00, ack}, 8'h00);
      cmp8({7'h00, tx}, 8'h01);
      m_u.stop();
      m_u.start();
      m_u.send(8'h54, ack);
      cmp8({7'h00, ack}, 8'h00);
      cmp8({7'h00, tx}, 8'h00);
      hold();
      wr_reg(`TWS_OFS_CTRL, 8'hc4);
      m_u.stop();
      repeat (20) @(posedge clk);
      rd_reg(`TWS_OFS_STAT, v);
      cmp8(v & 8'hf8, 8'ha0);
      wr_reg(`TWS_OFS_CTRL, 8'he4);
      repeat (4) @(posedge clk);
      cmp8({7'h00, went}, 8'h01);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd_reg(`TWS_OFS_STAT, v);
      cmp8(v & 8'hf8, 8'hf8);
      wr_reg(`TWS_OFS_OWN, 8'h55);
      rd_reg(`TWS_OFS_OWN, v);
      cmp8(v, 8'h55);
      wr_reg(`TWS_OFS_CTRL, 8'h44);
      rx_case(8'h54, 1'b0, 1'b0, 8'h60, 8'h80);
      rx_case(8'h54, 1'b1, 1'b0, 8'h68, 8'h80);
      rx_case(8'h00, 1'b0, 1'b0, 8'h70, 8'h90);
      rx_case(8'h00, 1'b1, 1'b0, 8'h78, 8'h90);
      rx_case(8'h54, 1'b0, 1'b1, 8'h60, 8'h80);
      off_case();
      close_out();
   end
endmodule
`default_nettype wire

// ===== tb/tws_master_model.sv
// bus master transmitter model; waits out clock stretching
`timescale 1ns/1ps
`default_nettype none
module tws_master_model (
   input  wire logic scl_w_i,   // clock wire level
   input  wire logic sda_w_i,   // data wire level
   output logic      scl_m_o,   // low pulls clock down
   output logic      sda_m_o    // low pulls data down
);
   localparam int QTR = 200;   // quarter of the 800 ns link period
   initial begin
      scl_m_o = 1'b1;
      sda_m_o = 1'b1;
   end
   // one clock pulse; the wait lets the slave hold the line low
   task automatic pulse(output logic s);
      #QTR scl_m_o = 1'b1;
      wait (scl_w_i);
      #QTR s = sda_w_i;
      #QTR scl_m_o = 1'b0;
      #QTR;
   endtask
   // start from an idle bus
   task automatic start();
      #(2*QTR) sda_m_o = 1'b0;
      #(2*QTR) scl_m_o = 1'b0;
   endtask
   // eight bits msb first, then the answer bit with data released
   task automatic send(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         sda_m_o = b[i];
         pulse(s);
      end
      sda_m_o = 1'b1;
      pulse(ack);
   endtask
   // stop; clock then stands still high
   task automatic stop();
      sda_m_o = 1'b0;
      #QTR scl_m_o = 1'b1;
      wait (scl_w_i);
      #(2*QTR) sda_m_o = 1'b1;
      #(2*QTR);
   endtask
endmodule
`default_nettype wire

// ===== tb/tws_rx_properties.sv
// port checker of the two-wire slave receiver
`timescale 1ns/1ps
`default_nettype none
`include "tws_defs.svh"
module tws_rx_chk (
   input wire logic       clock_i,
   input wire logic       rst_i,
   input wire logic [1:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic       wr_i,
   input wire logic       rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic       scl_i,
   input wire logic       scl_o,
   input wire logic       scl_oe_n_o,
   input wire logic       sda_i,
   input wire logic       sda_o,
   input wire logic       sda_oe_n_o,
   input wire logic       start_go_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   // software write that clears the pending flag
   wire logic clr_w = wr_i && addr_i == `TWS_OFS_CTRL && wdata_i[`TWS_B_IRQ];
   // own address written, then read back after a gap
   sequence own_wr_s;
      wr_i && addr_i == `TWS_OFS_OWN;
   endsequence
   sequence own_rd_s;
      rd_i && addr_i == `TWS_OFS_OWN;
   endsequence
   chk_sda_low_only: assert property (
      !sda_oe_n_o |-> !sda_o) else $error("data line driven high");
   chk_scl_low_only: assert property (
      !scl_oe_n_o |-> !scl_o) else $error("clock line driven high");
   chk_sda_edge_place: assert property (
      $changed(sda_oe_n_o) |-> !scl_i) else $error("data drive changed with clock high");
   chk_stretch_holds: assert property (
      !scl_oe_n_o && !clr_w && !$past(clr_w) |=> !scl_oe_n_o)
      else $error("clock stretch dropped without clear");
   chk_clear_release: assert property (
      !scl_oe_n_o && clr_w |-> ##[1:3] scl_oe_n_o) else $error("clear did not free clock");
   chk_reset_release: assert property (
      $fell(rst_i) |-> sda_oe_n_o && scl_oe_n_o) else $error("lines held after reset");
   chk_start_free: assert property (
      start_go_o |-> scl_i && sda_i) else $error("start launched on busy bus");
   chk_own_readback: assert property (
      own_wr_s ##2 own_rd_s |=> rdata_o == $past(wdata_i, 3))
      else $error("own address readback differs");
endmodule
bind tws_slave_rx tws_rx_chk chk_u (.clock_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
   .rdata_o, .scl_i, .scl_o, .scl_oe_n_o, .sda_i, .sda_o, .sda_oe_n_o, .start_go_o);
`default_nettype wire
